//--- shared/adc_ctrl_consts.vh
// Constants for the converter control block: register indexes, field positions,
// reset values and timing figures. Definitions only.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// Register indexes; the byte address is four times the index.
`define IDX_CTRLA 6'h00
`define IDX_CTRLB 6'h01
`define IDX_CTRLC 6'h02
`define IDX_CTRLD 6'h03
`define IDX_INTEN 6'h04
`define IDX_INTFLAG 6'h05
`define IDX_STATUS 6'h06
`define IDX_DBGCTRL 6'h07
`define IDX_CTRLE 6'h08
`define IDX_CTRLF 6'h09
`define IDX_COMMAND 6'h0a
`define IDX_POS_INPUT 6'h0c
`define IDX_RESULT 6'h10
`define IDX_SAMPLE 6'h14
`define IDX_WINLOW 6'h1c
`define IDX_WINHIGH 6'h1e

// Field positions.
`define BIT_ENABLE 0
`define BIT_LOW_LAT 5
`define BIT_STBYRUN 7
`define BIT_WIN_SRC 3
`define BIT_RES_RDY 0
`define BIT_SAMP_RDY 1
`define BIT_WINMATCH 2
`define BIT_RES_OVR 3
`define BIT_SAMP_OVR 4
`define BIT_TRIG_OVR 5

// Reset value of every control register.
`define RST_CTRL 8'h00

// Command start field settings and modes.
`define START_NOW 3'h1
`define START_ON_EVENT 3'h2
`define MODE_SINGLE 3'h0

// Window compare modes.
`define WIN_OFF 3'h0
`define WIN_BELOW 3'h1
`define WIN_ABOVE 3'h2
`define WIN_INSIDE 3'h3
`define WIN_OUTSIDE 3'h4

// Conversion clock cycles per sample after the sampling time.
`define CONV_BASE_SINGLE 10'd13
`define CONV_BASE_BURST 10'd12

// Timing.
`define CLK_PERIOD_NS 25
`define INIT_TIME_NS 6000

`endif

//--- verilog/adc_accum_window_event_ctrl.v
// Converter control: timing of single and burst conversions, window compare,
// events, interrupt flags, sleep and debug gating, Avalon-MM register slave.
// Assumes a converter core that presents its 10-bit code on adcData at the end
// of each conversion, and sleep/debug status from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_accum_window_event_ctrl
#(
  parameter INIT_NS = `INIT_TIME_NS
)
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata_ff,
  output reg waitrequest_ff,
  input wire startEvent,
  input wire [9:0] adcData,
  input wire sleepIdle,
  input wire sleepStandby,
  input wire deepSleep,
  input wire cpuHalted,
  output reg analogOn_ff,
  output reg sampling_ff,
  output reg evResRdy_ff,
  output reg evSampRdy_ff,
  output reg evWinMatch_ff,
  output reg irqResRdy_ff,
  output reg irqSampRdy_ff,
  output reg irqError_ff
);

  localparam [15:0] INIT_CYC = (INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_INIT = 3'd1;
  localparam [2:0] ST_CONV = 3'd2;
  localparam [2:0] ST_HALF = 3'd3;
  localparam [2:0] ST_UPD = 3'd4;
  localparam [2:0] ST_ACC = 3'd5;

  reg [7:0] ctrlA_ff;
  reg [3:0] presc_ff;
  reg [2:0] reference_select_ff;
  reg [3:0] ctrlD_ff;
  reg [5:0] intEn_ff;
  reg [5:0] flags_ff;
  reg haltContinue_ff;
  reg [7:0] sample_duration_ff;
  reg [2:0] accCount_ff;
  reg [2:0] startSel_ff;
  reg [2:0] convMode_ff;
  reg [5:0] positive_input_select_ff;
  reg [15:0] result_ff;
  reg [15:0] sample_ff;
  reg [15:0] winLow_ff;
  reg [15:0] winHigh_ff;
  reg sampleUnread_ff;
  reg resultUnread_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] divCnt_ff;
  reg halfTick_ff;
  reg [15:0] initCnt_ff;
  reg [9:0] halfCnt_ff;
  reg [6:0] sampCnt_ff;
  reg [15:0] acc_ff;
  reg evSync1_ff;
  reg evSync2_ff;
  reg evSync3_ff;
  reg [5:0] setFlags;
  reg [31:0] rdMux;

  wire enable = ctrlA_ff[`BIT_ENABLE];
  wire low_latency_keep_on = ctrlA_ff[`BIT_LOW_LAT];
  wire standbyRun = ctrlA_ff[`BIT_STBYRUN];
  wire winSrcSample = ctrlD_ff[`BIT_WIN_SRC];
  wire [2:0] winMode = ctrlD_ff[2:0];
  wire [5:0] regIdx = address[7:2];
  wire accept = (read | write) & ~waitrequest_ff;
  wire wrAcc = write & ~waitrequest_ff;
  wire rdAcc = read & ~waitrequest_ff;
  wire standbyBlocked = sleepStandby & ~standbyRun;
  wire debugBlocked = cpuHalted & ~haltContinue_ff;
  wire startImmediate = wrAcc & (regIdx == `IDX_COMMAND) & (writedata[2:0] == `START_NOW);
  wire evEdge = evSync2_ff & ~evSync3_ff;
  wire startOnEvent = evEdge & (startSel_ff == `START_ON_EVENT);
  wire canStart = enable & ~deepSleep & ~standbyBlocked & ~debugBlocked;
  wire trigger = canStart & (startImmediate | startOnEvent);
  wire keepOn = low_latency_keep_on & enable & ~deepSleep & ~standbyBlocked;
  wire [7:0] burstLen = 8'd1 << accCount_ff;
  wire lastSample = ({1'b0, sampCnt_ff} + 8'd1) >= burstLen;
  wire [9:0] convBase = (convMode_ff == `MODE_SINGLE) ? `CONV_BASE_SINGLE : `CONV_BASE_BURST;
  wire [9:0] convHalves = {convBase[8:0] + {1'b0, sample_duration_ff}, 1'b0};
  wire [9:0] sampHalves = {1'b0, sample_duration_ff, 1'b1};
  wire [15:0] newSample = {6'h00, adcData};
  wire [15:0] newSum = acc_ff + newSample;
  wire sampleStep = (state_ff == ST_UPD);
  wire resultStep = ((state_ff == ST_UPD) & lastSample & (burstLen == 8'd1)) |
    (state_ff == ST_ACC);
  wire [15:0] resultValue = (state_ff == ST_ACC) ? acc_ff : newSum;

  function winHit;
    input [2:0] mode;
    input [15:0] val;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (mode)
        `WIN_BELOW: winHit = val < lo;
        `WIN_ABOVE: winHit = val > hi;
        `WIN_INSIDE: winHit = (val > lo) & (val < hi);
        `WIN_OUTSIDE: winHit = (val < lo) | (val > hi);
        default: winHit = 1'b0;
      endcase
    end
  endfunction

  // Flags set this cycle; each event output mirrors the same terms.
  always @*
  begin
    setFlags = 6'h00;
    setFlags[`BIT_SAMP_RDY] = sampleStep;
    setFlags[`BIT_RES_RDY] = resultStep;
    setFlags[`BIT_SAMP_OVR] = sampleStep & sampleUnread_ff & ~(rdAcc & (regIdx == `IDX_SAMPLE));
    setFlags[`BIT_RES_OVR] = resultStep & resultUnread_ff & ~(rdAcc & (regIdx == `IDX_RESULT));
    setFlags[`BIT_TRIG_OVR] = (startImmediate | startOnEvent) & (state_ff != ST_IDLE);
    if (winSrcSample)
      setFlags[`BIT_WINMATCH] = sampleStep & winHit(winMode, newSample, winLow_ff, winHigh_ff);
    else
      setFlags[`BIT_WINMATCH] = resultStep & winHit(winMode, resultValue, winLow_ff, winHigh_ff);
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (trigger)
          nxt_state = (analogOn_ff & low_latency_keep_on) ? ST_CONV : ST_INIT;
      ST_INIT:
        if (initCnt_ff >= INIT_CYC - 16'd1)
          nxt_state = ST_CONV;
      ST_CONV:
        if (halfTick_ff & (halfCnt_ff >= convHalves - 10'd1))
          nxt_state = ST_HALF;
      ST_HALF:
        if (halfTick_ff)
          nxt_state = ST_UPD;
      ST_UPD:
        if (!lastSample)
          nxt_state = ST_CONV;
        else if (burstLen == 8'd1)
          nxt_state = ST_IDLE;
        else
          nxt_state = ST_ACC;
      ST_ACC:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (deepSleep)
      nxt_state = ST_IDLE;
  end

  always @*
  begin
    rdMux = 32'h00000000;
    case (regIdx)
      `IDX_CTRLA: rdMux[7:0] = ctrlA_ff;
      `IDX_CTRLB: rdMux[3:0] = presc_ff;
      `IDX_CTRLC: rdMux[2:0] = reference_select_ff;
      `IDX_CTRLD: rdMux[3:0] = ctrlD_ff;
      `IDX_INTEN: rdMux[5:0] = intEn_ff;
      `IDX_INTFLAG: rdMux[5:0] = flags_ff;
      `IDX_STATUS: rdMux[0] = (state_ff != ST_IDLE);
      `IDX_DBGCTRL: rdMux[0] = haltContinue_ff;
      `IDX_CTRLE: rdMux[7:0] = sample_duration_ff;
      `IDX_CTRLF: rdMux[2:0] = accCount_ff;
      `IDX_COMMAND: rdMux[7:0] = {1'b0, convMode_ff, 1'b0, startSel_ff};
      `IDX_POS_INPUT: rdMux[5:0] = positive_input_select_ff;
      `IDX_RESULT: rdMux[15:0] = result_ff;
      `IDX_SAMPLE: rdMux[15:0] = sample_ff;
      `IDX_WINLOW: rdMux[15:0] = winLow_ff;
      `IDX_WINHIGH: rdMux[15:0] = winHigh_ff;
      default: rdMux = 32'h00000000;
    endcase
  end

  // Bus slave: waitrequest drops for one cycle, one cycle after the request.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h00000000;
    end
    else
    begin
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
      if (read & waitrequest_ff)
        readdata_ff <= rdMux;
    end
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrlA_ff <= `RST_CTRL;
      presc_ff <= 4'h0;
      reference_select_ff <= 3'h0;
      ctrlD_ff <= 4'h0;
      intEn_ff <= 6'h00;
      haltContinue_ff <= 1'b0;
      sample_duration_ff <= `RST_CTRL;
      accCount_ff <= 3'h0;
      startSel_ff <= 3'h0;
      convMode_ff <= 3'h0;
      positive_input_select_ff <= 6'h00;
      winLow_ff <= 16'h0000;
      winHigh_ff <= 16'h0000;
    end
    else if (wrAcc)
    begin
      case (regIdx)
        `IDX_CTRLA: ctrlA_ff <= writedata[7:0] & 8'ha1;
        `IDX_CTRLB: presc_ff <= writedata[3:0];
        `IDX_CTRLC: reference_select_ff <= writedata[2:0];
        `IDX_CTRLD: ctrlD_ff <= writedata[3:0];
        `IDX_INTEN: intEn_ff <= writedata[5:0];
        `IDX_DBGCTRL: haltContinue_ff <= writedata[0];
        `IDX_CTRLE: sample_duration_ff <= writedata[7:0];
        `IDX_CTRLF: accCount_ff <= writedata[2:0];
        `IDX_COMMAND:
        begin
          startSel_ff <= writedata[2:0];
          convMode_ff <= writedata[6:4];
        end
        `IDX_POS_INPUT: positive_input_select_ff <= writedata[5:0];
        `IDX_WINLOW: winLow_ff <= writedata[15:0];
        `IDX_WINHIGH: winHigh_ff <= writedata[15:0];
        default: ctrlA_ff <= ctrlA_ff;
      endcase
    end
  end

  // Flags, unread markers and interrupt lines; a set beats a same-cycle clear.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_ff <= 6'h00;
      sampleUnread_ff <= 1'b0;
      resultUnread_ff <= 1'b0;
      irqResRdy_ff <= 1'b0;
      irqSampRdy_ff <= 1'b0;
      irqError_ff <= 1'b0;
      evResRdy_ff <= 1'b0;
      evSampRdy_ff <= 1'b0;
      evWinMatch_ff <= 1'b0;
    end
    else
    begin
      if (wrAcc & (regIdx == `IDX_INTFLAG))
        flags_ff <= (flags_ff & ~writedata[5:0]) | setFlags;
      else
        flags_ff <= flags_ff | setFlags;
      if (sampleStep)
        sampleUnread_ff <= 1'b1;
      else if (rdAcc & (regIdx == `IDX_SAMPLE))
        sampleUnread_ff <= 1'b0;
      if (resultStep)
        resultUnread_ff <= 1'b1;
      else if (rdAcc & (regIdx == `IDX_RESULT))
        resultUnread_ff <= 1'b0;
      evResRdy_ff <= setFlags[`BIT_RES_RDY];
      evSampRdy_ff <= setFlags[`BIT_SAMP_RDY];
      evWinMatch_ff <= setFlags[`BIT_WINMATCH];
      irqResRdy_ff <= (flags_ff[`BIT_RES_RDY] & intEn_ff[`BIT_RES_RDY]) |
        (~winSrcSample & flags_ff[`BIT_WINMATCH] & intEn_ff[`BIT_WINMATCH]);
      irqSampRdy_ff <= (flags_ff[`BIT_SAMP_RDY] & intEn_ff[`BIT_SAMP_RDY]) |
        (winSrcSample & flags_ff[`BIT_WINMATCH] & intEn_ff[`BIT_WINMATCH]);
      irqError_ff <= |(flags_ff[5:3] & intEn_ff[5:3]);
    end
  end

  // Start event synchroniser and conversion clock half-period divider.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      evSync1_ff <= 1'b0;
      evSync2_ff <= 1'b0;
      evSync3_ff <= 1'b0;
      divCnt_ff <= 4'h0;
      halfTick_ff <= 1'b0;
    end
    else
    begin
      evSync1_ff <= startEvent;
      evSync2_ff <= evSync1_ff;
      evSync3_ff <= evSync2_ff;
      if (divCnt_ff >= presc_ff)
      begin
        divCnt_ff <= 4'h0;
        halfTick_ff <= 1'b1;
      end
      else
      begin
        divCnt_ff <= divCnt_ff + 4'h1;
        halfTick_ff <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      initCnt_ff <= 16'h0000;
      halfCnt_ff <= 10'h000;
      sampCnt_ff <= 7'h00;
      acc_ff <= 16'h0000;
      sample_ff <= 16'h0000;
      result_ff <= 16'h0000;
      analogOn_ff <= 1'b0;
      sampling_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sampling_ff <= (nxt_state == ST_CONV) & ~deepSleep &
        ((state_ff != ST_CONV) | (halfCnt_ff < sampHalves));
      if (state_ff == ST_INIT)
        initCnt_ff <= initCnt_ff + 16'h0001;
      else
        initCnt_ff <= 16'h0000;
      // Counting runs on through the output steps so burst samples stay one period apart.
      if ((state_ff == ST_CONV) & halfTick_ff & (halfCnt_ff >= convHalves - 10'd1))
        halfCnt_ff <= 10'h000;
      else if (halfTick_ff & (state_ff >= ST_CONV) & (state_ff <= ST_UPD))
        halfCnt_ff <= halfCnt_ff + 10'h001;
      else if ((state_ff < ST_CONV) | (state_ff > ST_UPD))
        halfCnt_ff <= 10'h000;
      if (nxt_state == ST_INIT || nxt_state == ST_CONV)
        analogOn_ff <= 1'b1;
      else if (nxt_state == ST_IDLE)
        analogOn_ff <= keepOn & (analogOn_ff | (state_ff != ST_IDLE));
      if (state_ff == ST_IDLE)
      begin
        sampCnt_ff <= 7'h00;
        acc_ff <= 16'h0000;
      end
      if (sampleStep)
      begin
        sample_ff <= newSample;
        acc_ff <= newSum;
        sampCnt_ff <= sampCnt_ff + 7'h01;
      end
      if (resultStep)
        result_ff <= resultValue;
    end
  end

endmodule

`default_nettype wire

//--- test/adc_accum_window_event_ctrl_chk.sv
// Checker for the converter control block: bus handshake, event pulses,
// interrupt levels, analog power and deep sleep abort.
// Assumes a single clock domain and sees only the block's ports.
`timescale 1ns/100ps
`default_nettype none
module adc_accum_window_event_ctrl_chk
#(
  parameter INIT_NS = 6000
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest_ff,
  input wire logic deepSleep,
  input wire logic analogOn_ff,
  input wire logic sampling_ff,
  input wire logic evResRdy_ff,
  input wire logic evSampRdy_ff,
  input wire logic evWinMatch_ff,
  input wire logic irqResRdy_ff,
  input wire logic irqSampRdy_ff,
  input wire logic irqError_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property ((read || write) && waitrequest_ff |=> !waitrequest_ff)
    else $error("bus request not answered after one cycle");
  a_wait_single: assert property (!waitrequest_ff |=> waitrequest_ff)
    else $error("waitrequest low longer than one cycle");
  a_bus_idle: assert property (!(read || write) && waitrequest_ff |=> waitrequest_ff)
    else $error("waitrequest dropped without a request");
  a_res_pulse: assert property ($rose(evResRdy_ff) |=> !evResRdy_ff)
    else $error("result event longer than one cycle");
  a_samp_pulse: assert property (evSampRdy_ff |=> !evSampRdy_ff)
    else $error("sample event longer than one cycle");
  a_win_pulse: assert property (evWinMatch_ff ##1 evWinMatch_ff |-> 1'b0)
    else $error("window event longer than one cycle");
  a_res_irq_hold: assert property ($fell(irqResRdy_ff) |-> $past(write, 2))
    else $error("result request dropped without a register write");
  a_samp_irq_hold: assert property ($fell(irqSampRdy_ff) |-> $past(write, 2))
    else $error("sample request dropped without a register write");
  a_err_irq_hold: assert property ($fell(irqError_ff) |-> $past(write, 2))
    else $error("error request dropped without a register write");
  a_deep_abort: assert property (deepSleep |-> ##2 !sampling_ff)
    else $error("sampling continued in deep sleep");
  a_power_sampling: assert property (sampling_ff |-> analogOn_ff)
    else $error("sampling with analog power off");
  cover property (evSampRdy_ff ##[1:100] evSampRdy_ff);
  cover property (evWinMatch_ff);
  cover property ($rose(irqError_ff));
endmodule
`default_nettype wire

//--- test/event_irq_partner.sv
// Interrupt controller and event system model: counts event pulses, keeps
// the shortest spacing of sample events and issues start events.
// Assumes the block's clock; fire is a level from the testbench.
`timescale 1ns/100ps
`default_nettype none
module event_irq_partner
(
  input wire logic clk,
  input wire logic fire,
  input wire logic evSamp,
  input wire logic evWin,
  output wire logic startEvent
);
  logic fireLast_ff = 1'b0;
  logic [2:0] hold_ff = 3'h0;
  logic [31:0] gapCnt_ff = 32'h0;
  logic [31:0] sampCount_ff = 32'h0;
  logic [31:0] winCount_ff = 32'h0;
  logic [31:0] sampGap_ff = 32'hffff;
  always @(posedge clk)
  begin
    fireLast_ff <= fire;
    gapCnt_ff <= gapCnt_ff + 32'h1;
    if (fire && !fireLast_ff)
      hold_ff <= 3'h4;
    else if (hold_ff != 3'h0)
      hold_ff <= hold_ff - 3'h1;
    if (evSamp)
    begin
      sampCount_ff <= sampCount_ff + 32'h1;
      gapCnt_ff <= 32'h0;
      if (gapCnt_ff + 32'h1 < sampGap_ff)
        sampGap_ff <= gapCnt_ff + 32'h1;
    end
    if (evWin)
      winCount_ff <= winCount_ff + 32'h1;
  end
  // The event line idles low; the block keys on its rising edge.
  assign startEvent = (hold_ff != 3'h0);
endmodule
`default_nettype wire

//--- test/adc_accum_window_event_ctrl_tb.sv
// Testbench for the converter control block: register access over
// Avalon-MM, conversions, window modes, overruns, events, sleep and debug.
// Assumes the design constants header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_consts.vh"
module adc_accum_window_event_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [9:0] adcData = 10'h155;
  logic sleepIdle = 1'b0;
  logic sleepStandby = 1'b0;
  logic deepSleep = 1'b0;
  logic cpuHalted = 1'b0;
  logic fire = 1'b0;
  logic got;
  logic [31:0] v;
  logic [31:0] base;
  logic [4:0] winExp = 5'b10010;
  logic [5:0] runExp = 6'b110011;
  // Reference and input codes are the bench's own choice; the block only stores them.
  localparam [31:0] REF_2V048 = 32'h3;
  localparam [31:0] MUX_TEMP = 32'h1e;
  logic [31:0] wbase;
  integer cyc = 0;
  integer t0;
  integer m;
  integer n_fail = 0;
  integer total_checks = 0;
  wire [31:0] readdata_ff;
  wire waitrequest_ff, startEvent, analogOn_ff, sampling_ff, evResRdy_ff;
  wire evSampRdy_ff, evWinMatch_ff, irqResRdy_ff, irqSampRdy_ff, irqError_ff;

  always #12.5 clk = ~clk;

  always @(posedge clk)
    cyc <= cyc + 1;

  adc_accum_window_event_ctrl #(.INIT_NS(50)) DUT (.clk(clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata_ff(readdata_ff), .waitrequest_ff(waitrequest_ff), .startEvent(startEvent),
    .adcData(adcData), .sleepIdle(sleepIdle), .sleepStandby(sleepStandby),
    .deepSleep(deepSleep), .cpuHalted(cpuHalted), .analogOn_ff(analogOn_ff),
    .sampling_ff(sampling_ff), .evResRdy_ff(evResRdy_ff), .evSampRdy_ff(evSampRdy_ff),
    .evWinMatch_ff(evWinMatch_ff), .irqResRdy_ff(irqResRdy_ff),
    .irqSampRdy_ff(irqSampRdy_ff), .irqError_ff(irqError_ff));

  event_irq_partner partner (.clk(clk), .fire(fire), .evSamp(evSampRdy_ff),
    .evWin(evWinMatch_ff), .startEvent(startEvent));

  task tally_and_finish;
  begin
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // One access; holds the request until waitrequest is sampled low.
  task automatic bus(input logic wr, input [5:0] idx, input [31:0] wd, output [31:0] rd);
    integer i;
  begin
    address <= {idx, 2'b00};
    writedata <= wd;
    read <= !wr;
    write <= wr;
    i = 0;
    do
    begin
      @(posedge clk);
      i = i + 1;
    end
    while (waitrequest_ff !== 1'b0 && i < 40);
    rd = readdata_ff;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest_ff !== 1'b0)
    begin
      chk("bus answer", {31'h0, waitrequest_ff}, 32'h0);
      tally_and_finish();
    end
    @(posedge clk);
  end
  endtask

  task automatic wr(input [5:0] idx, input [31:0] d);
    logic [31:0] unused;
  begin
    bus(1'b1, idx, d, unused);
  end
  endtask

  task automatic rdChk(input string what, input [5:0] idx, input [31:0] exp);
    logic [31:0] seen;
  begin
    bus(1'b0, idx, 32'h0, seen);
    chk(what, seen, exp);
  end
  endtask

  task automatic waitRes(input integer lim, output logic found);
    integer i;
  begin
    found = 1'b0;
    for (i = 0; i < lim && !found; i = i + 1)
    begin
      @(posedge clk);
      found = (evResRdy_ff === 1'b1);
    end
  end
  endtask

  task automatic needRes;
    logic found;
  begin
    waitRes(400, found);
    chk("result event", {31'h0, found}, 32'h1);
    if (!found)
      tally_and_finish();
  end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdChk("ctrla reset", `IDX_CTRLA, 32'h0);
    rdChk("unmapped", 6'h0b, 32'h0);
    wr(`IDX_CTRLE, 32'h2);
    wr(`IDX_CTRLA, 32'h21);
    wr(`IDX_WINLOW, 32'h200);
    wr(`IDX_WINHIGH, 32'h300);
    for (m = 0; m < 5; m = m + 1)
    begin
      wr(`IDX_CTRLD, m);
      wr(`IDX_COMMAND, {29'h0, `START_NOW});
      needRes();
      rdChk("result", `IDX_RESULT, 32'h155);
      rdChk("sample", `IDX_SAMPLE, 32'h155);
      wr(`IDX_INTFLAG, 32'h0);
      rdChk("flags", `IDX_INTFLAG, {29'h0, winExp[m], 2'b11});
      wr(`IDX_INTFLAG, 32'h3f);
      rdChk("flags cleared", `IDX_INTFLAG, 32'h0);
      chk("power kept", {31'h0, analogOn_ff}, 32'h1);
    end
    chk("window events", partner.winCount_ff, 32'h2);
    wr(`IDX_CTRLD, 32'h0);
    wr(`IDX_INTEN, 32'h39);
    wr(`IDX_COMMAND, {29'h0, `START_NOW});
    needRes();
    wr(`IDX_COMMAND, {29'h0, `START_NOW});
    needRes();
    rdChk("overrun flags", `IDX_INTFLAG, 32'h1b);
    chk("irq result", {31'h0, irqResRdy_ff}, 32'h1);
    chk("irq error", {31'h0, irqError_ff}, 32'h1);
    chk("irq sample", {31'h0, irqSampRdy_ff}, 32'h0);
    wr(`IDX_INTFLAG, 32'h3f);
    repeat (2) @(posedge clk);
    chk("irq released", {30'h0, irqResRdy_ff, irqError_ff}, 32'h0);
    wr(`IDX_INTEN, 32'h04);
    wr(`IDX_CTRLD, 32'h0c);
    wr(`IDX_COMMAND, {29'h0, `START_NOW});
    needRes();
    @(posedge clk);
    chk("match on sample vector", {31'h0, irqSampRdy_ff}, 32'h1);
    chk("match off result vector", {31'h0, irqResRdy_ff}, 32'h0);
    wr(`IDX_CTRLF, 32'h2);
    base = partner.sampCount_ff;
    wbase = partner.winCount_ff;
    wr(`IDX_COMMAND, 32'h11);
    t0 = cyc;
    wr(`IDX_COMMAND, 32'h11);
    needRes();
    // Four samples of (2 + 12) conversion cycles, then 1.5 cycles; two clocks per cycle.
    chk("burst time", cyc - t0, 32'd115);
    rdChk("burst sum", `IDX_RESULT, 32'h554);
    chk("burst samples", partner.sampCount_ff - base, 32'h4);
    chk("sample window events", partner.winCount_ff - wbase, 32'h4);
    chk("sample spacing", partner.sampGap_ff, 32'd28);
    bus(1'b0, `IDX_INTFLAG, 32'h0, v);
    chk("trigger overrun", v & 32'h21, 32'h21);
    wr(`IDX_CTRLF, 32'h0);
    for (m = 0; m < 6; m = m + 1)
    begin
      wr(`IDX_CTRLA, (m == 5) ? 32'ha1 : 32'h21);
      wr(`IDX_DBGCTRL, {31'h0, m == 4});
      wr(`IDX_COMMAND, {29'h0, `START_ON_EVENT});
      sleepIdle <= (m == 1);
      sleepStandby <= (m == 2 || m == 5);
      cpuHalted <= (m == 3 || m == 4);
      fire <= 1'b1;
      waitRes(300, got);
      chk("event start", {31'h0, got}, {31'h0, runExp[m]});
      if (m == 5)
        chk("standby power", {31'h0, analogOn_ff}, 32'h1);
      fire <= 1'b0;
      sleepIdle <= 1'b0;
      sleepStandby <= 1'b0;
      cpuHalted <= 1'b0;
      repeat (100) @(posedge clk);
    end
    wr(`IDX_COMMAND, {29'h0, `START_NOW});
    repeat (6) @(posedge clk);
    deepSleep <= 1'b1;
    repeat (3) @(posedge clk);
    deepSleep <= 1'b0;
    waitRes(300, got);
    chk("aborted", {31'h0, got}, 32'h0);
    adcData <= 10'h2a7;
    wr(`IDX_CTRLB, 32'h3);
    wr(`IDX_CTRLC, REF_2V048);
    wr(`IDX_POS_INPUT, MUX_TEMP);
    // 35 us at the 5 MHz conversion clock that a prescaler of 3 gives.
    wr(`IDX_CTRLE, 32'haf);
    wr(`IDX_COMMAND, {29'h0, `START_NOW});
    waitRes(2000, got);
    chk("temperature done", {31'h0, got}, 32'h1);
    rdChk("temperature code", `IDX_RESULT, 32'h2a7);
    rdChk("temperature input", `IDX_POS_INPUT, MUX_TEMP);
    tally_and_finish();
  end
endmodule

bind adc_accum_window_event_ctrl adc_accum_window_event_ctrl_chk #(.INIT_NS(INIT_NS)) chk_i (
  .clk(clk), .sys_rst(sys_rst), .read(read), .write(write),
  .waitrequest_ff(waitrequest_ff), .deepSleep(deepSleep), .analogOn_ff(analogOn_ff),
  .sampling_ff(sampling_ff), .evResRdy_ff(evResRdy_ff), .evSampRdy_ff(evSampRdy_ff),
  .evWinMatch_ff(evWinMatch_ff), .irqResRdy_ff(irqResRdy_ff),
  .irqSampRdy_ff(irqSampRdy_ff), .irqError_ff(irqError_ff));
`default_nettype wire
